// File: src/ccu_clock_trim_lock.sv
// clock trim, fixed frequency clock, lock detector and clock monitor with APB registers
// assumes all inputs synchronous to clk; clocks are modelled as toggling flops paced by ticks
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ccu_clock_trim_lock
  import ccu_pkg::*;
#(
  parameter int LOC_CYCLES_P = LOC_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system side
  input  wire logic [8:0]  factoryTrim,
  input  wire logic        stopMode,
  input  wire logic        extRefClk,
  input  wire logic        extClkAvail,
  input  wire logic        extRangeHigh,
  // clock and event outputs
  output logic             auxIntRefClk,
  output logic             mainOutClk,
  output logic             fixedFreqClk,
  output logic             fixedFreqValid,
  output logic             lossOfLockIrq,
  output logic             chipResetReq,
  output logic             lossOfClockSrc
);

  logic [1:0]  clockSelReg;
  logic [2:0]  refDivReg;
  logic        refSelReg;
  logic        outEnReg;
  logic        stopEnReg;
  logic [2:0]  busDivReg;
  logic        lowPowerReg;
  logic [7:0]  coarseTrimReg;
  logic        fineTrimReg;
  logic        lolIrqEnReg;
  logic        monEnReg;
  logic        lolFlagReg;
  logic        lolFlagNext;
  logic [1:0]  clkStatusReg;
  logic        refStatusReg;
  logic [3:0]  syncCntReg;
  logic        trimLoadReg;
  logic        extPrevReg;
  logic [15:0] extGapReg;
  logic [15:0] extPeriodReg;
  logic [3:0]  lockCntReg;
  logic        lockedReg;
  logic        refStatusPrev;
  logic [2:0]  refDivPrev;
  logic [8:0]  trimPrev;
  ccu_mode_t   mode;
  logic        wrEn;
  logic        setupPhase;
  logic        addrHit;
  logic [7:0]  readMux;
  logic        lolClr;
  logic        extEdge;
  logic        intRefRun;
  logic        intTick;
  logic        fllTick;
  logic        srcTick;
  logic        mainTick;
  logic        refTick;
  logic        ffTick;
  logic        fllOn;
  logic        disturb;
  logic        lolEvent;
  logic        monActive;
  logic        locFire;
  logic        ffValidNext;
  logic        clkAvail;
  logic        refAvail;
  logic [15:0] intPeriod;
  logic [15:0] fllRaw;
  logic [15:0] fllPeriod;

  // apb decode: zero wait states, answer in the access cycle
  assign setupPhase = psel && !penable;
  assign wrEn       = psel && penable && pwrite;
  assign lolClr     = wrEn && (paddr == STATUS_OFFSET) && pwdata[LOL_FLAG_BIT] && lolFlagReg;

  always_comb begin
    addrHit = 1'b1;
    readMux = 8'h00;
    unique case (paddr)
      CTRL1_OFFSET:  readMux = {clockSelReg, refDivReg, refSelReg, outEnReg, stopEnReg};
      CTRL2_OFFSET:  readMux = {busDivReg, lowPowerReg, 4'h0};
      CTRL3_OFFSET:  readMux = coarseTrimReg;
      CTRL4_OFFSET:  readMux = {lolIrqEnReg, 1'b0, monEnReg, 4'h0, fineTrimReg};
      STATUS_OFFSET: readMux = {lolFlagReg, lockedReg, 1'b0, refStatusReg, clkStatusReg, 2'h0};
      default:       addrHit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !addrHit;
      if (setupPhase && !pwrite) begin
        prdata <= {24'h00_0000, readMux};
      end
    end
  end

  // control registers; a clock select of 11 is reserved and ignored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clockSelReg <= CLK_SEL_RESET;
      refDivReg   <= REF_DIV_RESET;
      refSelReg   <= REF_SEL_RESET;
      outEnReg    <= 1'b0;
      stopEnReg   <= 1'b0;
      busDivReg   <= BUS_DIV_RESET;
      lowPowerReg <= 1'b0;
      lolIrqEnReg <= 1'b0;
      monEnReg    <= 1'b0;
    end else if (wrEn) begin
      if (paddr == CTRL1_OFFSET) begin
        if (pwdata[CLK_SEL_LSB+:2] != 2'h3) begin
          clockSelReg <= pwdata[CLK_SEL_LSB+:2];
        end
        refDivReg <= pwdata[REF_DIV_LSB+:3];
        refSelReg <= pwdata[REF_SEL_BIT];
        outEnReg  <= pwdata[OUT_EN_BIT];
        stopEnReg <= pwdata[STOP_EN_BIT];
      end
      if (paddr == CTRL2_OFFSET) begin
        busDivReg   <= pwdata[BUS_DIV_LSB+:3];
        lowPowerReg <= pwdata[LOW_POWER_BIT];
      end
      if (paddr == CTRL4_OFFSET) begin
        lolIrqEnReg <= pwdata[LOL_IE_BIT];
        monEnReg    <= pwdata[MON_EN_BIT];
      end
    end
  end

  // trim: factory value caught on the first edge after release, then software owned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trimLoadReg   <= 1'b1;
      coarseTrimReg <= COARSE_TRIM_RESET;
      fineTrimReg   <= 1'b0;
    end else if (trimLoadReg) begin
      trimLoadReg   <= 1'b0;
      coarseTrimReg <= factoryTrim[8:1];
      fineTrimReg   <= factoryTrim[0];
    end else if (wrEn) begin
      if (paddr == CTRL3_OFFSET) begin
        coarseTrimReg <= pwdata[7:0];
      end
      if (paddr == CTRL4_OFFSET) begin
        fineTrimReg <= pwdata[FINE_TRIM_BIT];
      end
    end
  end

  a_trim_load: assert property (@(posedge clk) disable iff (!reset_n)
    trimLoadReg |=> (coarseTrimReg == $past(factoryTrim[8:1])) && (fineTrimReg == $past(factoryTrim[0])))
    else $error("factory trim not loaded after reset");

  // status follows selection after the sync delay; an unavailable clock keeps the old one
  assign refAvail = refSelReg || extClkAvail;
  assign clkAvail = (clockSelReg != CLK_SEL_EXT) || extClkAvail;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clkStatusReg <= CLK_SEL_RESET;
      refStatusReg <= REF_SEL_RESET;
      syncCntReg   <= 4'h0;
    end else if ((clockSelReg == clkStatusReg) && (refSelReg == refStatusReg)) begin
      syncCntReg <= 4'h0;
    end else if (syncCntReg == 4'(SYNC_CYCLES - 1)) begin
      syncCntReg <= 4'h0;
      if (clkAvail) begin
        clkStatusReg <= clockSelReg;
      end
      if (refAvail) begin
        refStatusReg <= refSelReg;
      end
    end else begin
      syncCntReg <= syncCntReg + 4'h1;
    end
  end

  a_status_sync: assert property (@(posedge clk) disable iff (!reset_n)
    (clockSelReg != clkStatusReg) && (syncCntReg == 4'h0) |=> $stable(clkStatusReg))
    else $error("clock mode status moved without synchronisation");

  // mode from the synchronised status; low power only affects the bypass modes
  always_comb begin
    unique case (clkStatusReg)
      CLK_SEL_FLL: mode = refStatusReg ? ENGAGED_INT : ENGAGED_EXT;
      CLK_SEL_INT: mode = lowPowerReg ? BYPASS_INT_LP : BYPASS_INT;
      CLK_SEL_EXT: mode = lowPowerReg ? BYPASS_EXT_LP : BYPASS_EXT;
      default:     mode = ENGAGED_INT;
    endcase
  end

  assign fllOn = !stopMode && (mode != BYPASS_INT_LP) && (mode != BYPASS_EXT_LP);

  // external reference edge, gap and period measurement
  assign extEdge = extRefClk && !extPrevReg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extPrevReg   <= 1'b0;
      extGapReg    <= 16'h0000;
      extPeriodReg <= EXT_PERIOD_RESET;
    end else begin
      extPrevReg <= extRefClk;
      if (extEdge) begin
        extGapReg    <= 16'h0000;
        extPeriodReg <= extGapReg + 16'h0001;
      end else if (extGapReg != 16'hffff) begin
        extGapReg <= extGapReg + 16'h0001;
      end
    end
  end

  // internal reference: period grows with the trim code
  assign intPeriod = INT_REF_BASE + 16'(coarseTrimReg) + 16'(fineTrimReg);
  assign intRefRun = !stopMode || (stopEnReg && outEnReg);

  ccu_tick_div #(.W(16)) u_int_div (
    .clk     (clk),
    .reset_n (reset_n),
    .tickIn  (intRefRun),
    .period  (intPeriod),
    .tickOut (intTick)
  );

  // fll modelled as a fixed multiple of the selected reference rate
  assign fllRaw    = refStatusReg ? intPeriod : extPeriodReg;
  assign fllPeriod = ((fllRaw >> FLL_SHIFT) == 16'h0000) ? 16'h0001 : (fllRaw >> FLL_SHIFT);

  ccu_tick_div #(.W(16)) u_fll_div (
    .clk     (clk),
    .reset_n (reset_n),
    .tickIn  (fllOn),
    .period  (fllPeriod),
    .tickOut (fllTick)
  );

  always_comb begin
    unique case (mode)
      ENGAGED_INT, ENGAGED_EXT:   srcTick = fllTick;
      BYPASS_INT, BYPASS_INT_LP:  srcTick = intTick && !stopMode;
      BYPASS_EXT, BYPASS_EXT_LP:  srcTick = extEdge && !stopMode;
      default:                    srcTick = 1'b0;
    endcase
  end

  ccu_tick_div #(.W(16)) u_bus_div (
    .clk     (clk),
    .reset_n (reset_n),
    .tickIn  (srcTick),
    .period  (16'h0001 << busDivReg),
    .tickOut (mainTick)
  );

  assign refTick = refStatusReg ? intTick : extEdge;

  ccu_tick_div #(.W(16)) u_ref_div (
    .clk     (clk),
    .reset_n (reset_n),
    .tickIn  (refTick && !stopMode),
    .period  (16'h0001 << refDivReg),
    .tickOut (ffTick)
  );

  // fixed frequency validity against the main output rate
  always_comb begin
    unique case (mode)
      ENGAGED_INT, ENGAGED_EXT:  ffValidNext = 1'b1;
      BYPASS_INT, BYPASS_INT_LP: ffValidNext = 1'b0;
      BYPASS_EXT, BYPASS_EXT_LP: ffValidNext = !extRangeHigh || ({1'b0, refDivReg} >= ({1'b0, busDivReg} + 4'h2));
      default:                   ffValidNext = 1'b0;
    endcase
  end

  // clock outputs; all toggle on their own tick only, so they hold still in stop, except aux when stopEnReg and outEnReg are set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auxIntRefClk   <= 1'b0;
      mainOutClk     <= 1'b0;
      fixedFreqClk   <= 1'b0;
      fixedFreqValid <= 1'b0;
    end else begin
      if (intTick && outEnReg) begin
        auxIntRefClk <= !auxIntRefClk;
      end
      if (mainTick) begin
        mainOutClk <= !mainOutClk;
      end
      if (ffTick) begin
        fixedFreqClk <= !fixedFreqClk;
      end
      fixedFreqValid <= ffValidNext;
    end
  end

  a_aux_gated: assert property (@(posedge clk) disable iff (!reset_n)
    !outEnReg |=> $stable(auxIntRefClk))
    else $error("aux clock toggled with output disabled");
  a_aux_stop: assert property (@(posedge clk) disable iff (!reset_n)
    stopMode && !(stopEnReg && outEnReg) |=> $stable(auxIntRefClk))
    else $error("aux clock ran in stop without stop enable");
  a_ff_bypass_int: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == BYPASS_INT) ##1 (mode == BYPASS_INT) |-> !fixedFreqValid)
    else $error("fixed clock valid in internal bypass");

  // lock detector; a reference, divider or internal trim change drops lock
  assign disturb = (refStatusReg != refStatusPrev) || (refDivReg != refDivPrev)
                || (refStatusReg && ({coarseTrimReg, fineTrimReg} != trimPrev))
                || (!refStatusReg && (extGapReg == 16'(REF_GAP_CYCLES - 1)));
  assign lolEvent = lockedReg && fllOn && disturb;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refStatusPrev <= REF_SEL_RESET;
      refDivPrev    <= REF_DIV_RESET;
      trimPrev      <= {COARSE_TRIM_RESET, 1'b0};
      lockCntReg    <= 4'h0;
      lockedReg     <= 1'b0;
    end else begin
      refStatusPrev <= refStatusReg;
      refDivPrev    <= refDivReg;
      trimPrev      <= {coarseTrimReg, fineTrimReg};
      if (!fllOn || disturb) begin
        lockCntReg <= 4'h0;
        lockedReg  <= 1'b0;
      end else if (refTick && !lockedReg) begin
        lockCntReg <= lockCntReg + 4'h1;
        lockedReg  <= (lockCntReg + 4'h1) == LOCK_REF_TICKS;
      end
    end
  end

  // sticky flag: a new loss of lock wins over a same-cycle clear
  assign lolFlagNext = lolEvent || (lolFlagReg && !lolClr);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lolFlagReg    <= 1'b0;
      lossOfLockIrq <= 1'b0;
    end else begin
      lolFlagReg    <= lolFlagNext;
      lossOfLockIrq <= lolFlagNext && lolIrqEnReg;
    end
  end

  a_lol_set: assert property (@(posedge clk) disable iff (!reset_n)
    lolEvent |=> lolFlagReg ##0 (lossOfLockIrq == $past(lolIrqEnReg)))
    else $error("loss of lock not flagged");
  a_lol_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (lolFlagReg && !lolEvent) |=> (lolFlagReg == !$past(lolClr)))
    else $error("loss of lock flag clear misbehaved");
  a_lp_no_lock: assert property (@(posedge clk) disable iff (!reset_n)
    (mode == BYPASS_INT_LP || mode == BYPASS_EXT_LP) |=> !lockedReg ##0 (lolFlagReg == $past(lolFlagReg && !lolClr)))
    else $error("lock activity in low power bypass");
  a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    (!lolIrqEnReg ##1 !lolIrqEnReg) |-> !lossOfLockIrq)
    else $error("interrupt raised while disabled");

  // external clock monitor: one reset request per timeout, loss marker sticky until reset
  assign monActive = monEnReg && ((mode == ENGAGED_EXT) || (mode == BYPASS_EXT) || (mode == BYPASS_EXT_LP));
  assign locFire   = monActive && (extGapReg == 16'(LOC_CYCLES_P - 1)) && !extEdge;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chipResetReq   <= 1'b0;
      lossOfClockSrc <= 1'b0;
    end else begin
      chipResetReq <= locFire;
      if (locFire) begin
        lossOfClockSrc <= 1'b1;
      end
    end
  end

  a_loc_reset: assert property (@(posedge clk) disable iff (!reset_n)
    locFire |=> chipResetReq && lossOfClockSrc ##1 !chipResetReq)
    else $error("loss of clock did not request one reset");
  a_mon_off: assert property (@(posedge clk) disable iff (!reset_n)
    !monActive |=> !chipResetReq)
    else $error("reset requested with monitor inactive");

endmodule
`default_nettype wire

// File: src/ccu_pkg.sv
// constants, register map and mode type of the internal clock trim and lock monitor
// assumes a 10 MHz system clock and a 32-bit APB master reaching the registers
package ccu_pkg;

  localparam logic [11:0] CTRL1_OFFSET  = 12'h000;
  localparam logic [11:0] CTRL2_OFFSET  = 12'h004;
  localparam logic [11:0] CTRL3_OFFSET  = 12'h008;
  localparam logic [11:0] CTRL4_OFFSET  = 12'h00c;
  localparam logic [11:0] STATUS_OFFSET = 12'h010;

  // control 1 fields
  localparam int CLK_SEL_LSB   = 6;
  localparam int REF_DIV_LSB   = 3;
  localparam int REF_SEL_BIT   = 2;
  localparam int OUT_EN_BIT    = 1;
  localparam int STOP_EN_BIT   = 0;
  // control 2 fields
  localparam int BUS_DIV_LSB   = 5;
  localparam int LOW_POWER_BIT = 4;
  // control 4 fields
  localparam int LOL_IE_BIT    = 7;
  localparam int MON_EN_BIT    = 5;
  localparam int FINE_TRIM_BIT = 0;
  // status fields
  localparam int LOL_FLAG_BIT  = 7;
  localparam int LOCKED_BIT    = 6;
  localparam int REF_ST_BIT    = 4;
  localparam int CLK_ST_LSB    = 2;

  localparam logic [1:0] CLK_SEL_FLL     = 2'h0;
  localparam logic [1:0] CLK_SEL_INT     = 2'h1;
  localparam logic [1:0] CLK_SEL_EXT     = 2'h2;
  localparam logic [1:0] CLK_SEL_RESET   = 2'h0;
  localparam logic [2:0] REF_DIV_RESET   = 3'h0;
  localparam logic       REF_SEL_RESET   = 1'b1;
  localparam logic [2:0] BUS_DIV_RESET   = 3'h1;
  localparam logic [7:0] COARSE_TRIM_RESET = 8'h80;

  // timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int SYNC_NS            = 200;
  localparam int SYNC_CYCLES        = (SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOC_TIMEOUT_NS     = 100000;
  localparam int LOC_CYCLES         = LOC_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int REF_GAP_NS         = 100000;
  localparam int REF_GAP_CYCLES     = REF_GAP_NS / CLK_PERIOD_NS;
  localparam logic [15:0] INT_REF_BASE     = 16'h0010;
  localparam logic [15:0] EXT_PERIOD_RESET = 16'h0004;
  localparam logic [3:0]  LOCK_REF_TICKS   = 4'h8;
  localparam int FLL_SHIFT          = 2;

  typedef enum logic [2:0] {
    ENGAGED_INT,
    ENGAGED_EXT,
    BYPASS_INT,
    BYPASS_INT_LP,
    BYPASS_EXT,
    BYPASS_EXT_LP
  } ccu_mode_t;

endpackage

// File: src/ccu_tick_div.sv
// divides a tick stream by a programmable period, one output tick per period
// assumes period is held steady while ticks arrive; period 0 or 1 passes every tick
`timescale 1ns/1ns
`default_nettype none
module ccu_tick_div #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // tick stream
  input  wire logic         tickIn,
  input  wire logic [W-1:0] period,
  output logic              tickOut
);

  logic [W-1:0] cntReg;
  logic [W-1:0] cntInc;
  logic         wrap;

  assign cntInc  = cntReg + W'(1);
  assign wrap    = (cntInc >= period);
  assign tickOut = tickIn && wrap;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cntReg <= '0;
    end else if (tickIn) begin
      cntReg <= wrap ? '0 : cntInc;
    end
  end

  a_div_passthru: assert property (@(posedge clk) disable iff (!reset_n)
    (tickIn && period <= W'(1)) |-> tickOut)
    else $error("divider dropped a tick at period one");

endmodule
`default_nettype wire

// File: tb/ccu_clock_trim_lock_test.sv
// self-checking bench for the clock trim and lock monitor, one task per scenario
// assumes ccu_pkg register map; bench drives every port itself, no partner model
`timescale 1ns/1ns
`default_nettype none
module ccu_clock_trim_lock_test;
  import ccu_pkg::*;
  // short monitor timeout keeps the run brief
  localparam int LOC_SIM = 20;
  logic        clk          = 1'b0;
  logic        reset_n      = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h0;
  logic [8:0]  factoryTrim  = 9'h0a3;
  logic        stopMode     = 1'b0;
  logic        extRefClk    = 1'b0;
  logic        extClkAvail  = 1'b0;
  logic        extRangeHigh = 1'b0;
  logic        extRun       = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, auxIntRefClk, mainOutClk, fixedFreqClk;
  logic        fixedFreqValid, lossOfLockIrq, chipResetReq, lossOfClockSrc;
  logic [31:0] q;
  logic        e;
  int          n;
  int          fails  = 0;
  int          checks = 0;

  ccu_clock_trim_lock #(.LOC_CYCLES_P(LOC_SIM)) dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .factoryTrim(factoryTrim), .stopMode(stopMode), .extRefClk(extRefClk),
    .extClkAvail(extClkAvail), .extRangeHigh(extRangeHigh), .auxIntRefClk(auxIntRefClk),
    .mainOutClk(mainOutClk), .fixedFreqClk(fixedFreqClk), .fixedFreqValid(fixedFreqValid),
    .lossOfLockIrq(lossOfLockIrq), .chipResetReq(chipResetReq), .lossOfClockSrc(lossOfClockSrc)
  );

  initial begin
    forever #50 clk = ~clk;
  end
  // external reference: one rising edge every two cycles while running, frozen otherwise
  always @(posedge clk) begin
    if (extRun) extRefClk <= ~extRefClk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held from setup until pready is sampled high, data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function automatic logic pick(input int w);
    return (w == 2) ? fixedFreqClk : (w != 0) ? mainOutClk : auxIntRefClk;
  endfunction

  // length of the second full interval between toggles, in cycles
  task automatic gap(input int w);
    logic last;
    repeat (3) begin
      last = pick(w);
      n = 0;
      while (pick(w) === last && n < 400) begin
        @(posedge clk);
        n++;
      end
    end
  endtask

  task automatic t_reset();
    apb(0, CTRL1_OFFSET, 0);  chk(q, 32'h04);
    apb(0, CTRL2_OFFSET, 0);  chk(q, 32'h20);
    apb(0, CTRL3_OFFSET, 0);  chk(q, 32'h51);
    apb(0, CTRL4_OFFSET, 0);  chk(q, 32'h01);
    apb(0, STATUS_OFFSET, 0); chk(q & 32'hbf, 32'h10);
    apb(0, 12'h014, 0);       chk({q[30:0], e}, 32'h1);
  endtask

  task automatic t_aux();
    apb(1, CTRL4_OFFSET, 0);
    apb(1, CTRL3_OFFSET, 32'h04);
    gap(0); chk(n, 400);
    apb(1, CTRL1_OFFSET, 32'h06);
    gap(0); chk(n, 20);
    apb(1, CTRL3_OFFSET, 32'h08);
    gap(0); chk(n, 24);
    stopMode <= 1'b1;
    gap(0); chk(n, 400);
    apb(1, CTRL1_OFFSET, 32'h07);
    gap(0); chk(n, 24);
    stopMode <= 1'b0;
  endtask

  task automatic t_mode();
    apb(1, CTRL1_OFFSET, 32'h80);
    repeat (10) @(posedge clk);
    apb(0, STATUS_OFFSET, 0); chk(q & 32'h1c, 32'h10);
    extClkAvail <= 1'b1;
    extRun <= 1'b1;
    repeat (10) @(posedge clk);
    apb(0, STATUS_OFFSET, 0); chk(q & 32'h1c, 32'h08);
    apb(1, CTRL1_OFFSET, 32'h00);
    repeat (30) @(posedge clk);
    apb(0, STATUS_OFFSET, 0); chk(q & 32'h5c, 32'h40);
    apb(1, CTRL1_OFFSET, 32'h44);
    repeat (10) @(posedge clk);
    apb(0, STATUS_OFFSET, 0); chk(q & 32'h1c, 32'h14);
    chk(fixedFreqValid, 0);
  endtask

  task automatic t_fixed();
    extRangeHigh <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      for (int r = b + 1; r <= b + 2; r++) begin
        apb(1, CTRL2_OFFSET, b << 5);
        apb(1, CTRL1_OFFSET, 32'h80 | (r << 3));
        repeat (8) @(posedge clk);
        chk(fixedFreqValid, (r >= b + 2) ? 1 : 0);
      end
    end
    extRangeHigh <= 1'b0;
    apb(1, CTRL1_OFFSET, 32'h80);
    repeat (8) @(posedge clk);
    chk(fixedFreqValid, 1);
    gap(1); chk(n, 16);
    apb(1, CTRL2_OFFSET, 32'h70);
    gap(1); chk(n, 16);
    apb(1, CTRL1_OFFSET, 32'h90);
    gap(2); chk(n, 8);
    apb(1, CTRL2_OFFSET, 32'h20);
  endtask

  task automatic t_lock();
    int k;
    apb(1, CTRL1_OFFSET, 32'h04);
    apb(1, CTRL3_OFFSET, 32'h00);
    k = 0;
    do begin
      repeat (10) @(posedge clk);
      apb(0, STATUS_OFFSET, 0);
      k++;
    end while (q[LOCKED_BIT] !== 1'b1 && k < 200);
    chk(q[LOCKED_BIT], 1);
    apb(1, STATUS_OFFSET, 32'h80);
    apb(1, CTRL4_OFFSET, 32'h80); chk(lossOfLockIrq, 0);
    apb(1, CTRL3_OFFSET, 32'h01);
    repeat (3) @(posedge clk);
    chk(lossOfLockIrq, 1);
    apb(1, STATUS_OFFSET, 32'h00);
    apb(0, STATUS_OFFSET, 0); chk(q[LOL_FLAG_BIT], 1);
    apb(1, STATUS_OFFSET, 32'h80);
    apb(0, STATUS_OFFSET, 0); chk(q[LOL_FLAG_BIT], 0);
    chk(lossOfLockIrq, 0);
    apb(1, CTRL2_OFFSET, 32'h30);
    apb(1, CTRL1_OFFSET, 32'h44);
    repeat (300) @(posedge clk);
    apb(1, CTRL3_OFFSET, 32'h02);
    repeat (5) @(posedge clk);
    apb(0, STATUS_OFFSET, 0); chk(q & 32'hc0, 32'h0);
    gap(1); chk(n, 36);
    apb(1, CTRL2_OFFSET, 32'h20);
  endtask

  task automatic t_monitor();
    int k;
    apb(1, CTRL4_OFFSET, 32'h20);
    extRun <= 1'b0;
    repeat (60) @(posedge clk);
    chk(lossOfClockSrc, 0);
    extRun <= 1'b1;
    apb(1, CTRL1_OFFSET, 32'h80);
    repeat (60) @(posedge clk);
    chk(lossOfClockSrc, 0);
    extRun <= 1'b0;
    k = 0;
    while (chipResetReq !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk(chipResetReq, 1);
    @(posedge clk);
    chk(lossOfClockSrc, 1);
  endtask

  // mid-run reset: sticky loss marker clears and a new factory trim is loaded
  task automatic t_rereset();
    factoryTrim <= 9'h15c;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(lossOfClockSrc, 0);
    apb(0, CTRL3_OFFSET, 0); chk(q, 32'hae);
    apb(0, CTRL4_OFFSET, 0); chk(q, 32'h00);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_aux();
    t_mode();
    t_fixed();
    t_lock();
    t_monitor();
    t_rereset();
    summarize();
  end
endmodule
`default_nettype wire
